// ===== logic/mcr_pkg.sv
// package for the measurement control register block
// assumes a byte-wide register port already decoded from the serial interface
package mcr_pkg;
    localparam logic [7:0] MCR_ADDR          = 8'h3e;
    localparam logic [7:0] MCR_RESET         = 8'h00;
    localparam int         MCR_OR_DIS_BIT    = 7;
    localparam int         MCR_AUTODOZE_BIT  = 6;
    localparam int         MCR_SEQ_HI        = 5;
    localparam int         MCR_SEQ_LO        = 4;
    localparam int         MCR_QUIET_BIT     = 3;
    localparam int         MCR_BW_HI         = 2;
    localparam int         MCR_BW_LO         = 0;
    localparam logic [1:0] MCR_SEQ_DEFAULT   = 2'h0;
    localparam logic [1:0] MCR_SEQ_LINKED    = 2'h1;
    localparam logic [1:0] MCR_SEQ_LOOPED    = 2'h2;
    localparam logic [2:0] MCR_BW_MAX        = 3'h4;
    localparam logic [1:0] MCR_MODE_WAKEUP   = 2'h1;

    // detector arming state, one-hot
    typedef enum logic [1:0] {
        MCR_ARM_ACT   = 2'b01,
        MCR_ARM_STILL = 2'b10
    } mcr_arm_t;
endpackage

// ===== logic/mcr_bw_decode.sv
// bandwidth code decoder for the low-pass corner select
// assumes the code arrives straight from the control register
`timescale 1ns/1ns
module mcr_bw_decode
    import mcr_pkg::*;
(
    input  wire logic [2:0] bw_code,
    output logic      [4:0] bw_onehot
);
    // one-hot corner select; undefined codes fall back to the lowest corner
    assign bw_onehot = (bw_code > MCR_BW_MAX) ? 5'h01 : 5'(5'h01 << bw_code); // R9
endmodule

// ===== logic/mcr_top.sv
// measurement control register with activity/stillness sequencing
// assumes reg_* strobes are single-cycle and synchronous to clk
//
// Operation
// [R1] the register sits at 0x3e, resets to 0x00, all fields read/write, bit 7 disables overrange.
// [R2] with auto-doze set, detected stillness forces wake-up mode.
// [R3] auto-doze is ignored unless sequencing is linked or looped.
// [R4] sequencing 0 runs both detectors at once, events pending until status is read.
// [R5] sequencing 1 arms one detector at a time, host acknowledges by reading status.
// [R6] sequencing 2 alternates detectors and acknowledges events internally.
// [R7] linked or looped applies only when both axis enable sets are all ones.
// [R8] the quiet bit selects low-noise operation.
// [R9] bits 2:0 pick the four-pole low-pass corner 160 to 2560 Hz.
// [R10] in linked or looped sequencing, an event arms the other detector.
`timescale 1ns/1ns
module mcr_top
    import mcr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       status_rd,
    input  wire logic [2:0] motion_axis_enable,
    input  wire logic [2:0] stillness_axis_enable,
    input  wire logic       motion_hit,
    input  wire logic       stillness_hit,
    output logic            motion_armed,
    output logic            stillness_armed,
    output logic            motion_pending,
    output logic            stillness_pending,
    output logic            wakeup_request,
    output logic            overrange_disable,
    output logic            quiet_mode,
    output logic      [4:0] lpf_corner_sel
);
    logic [7:0] measurement_control;
    mcr_arm_t   arm;
    mcr_arm_t   next_arm;

    // field decode
    wire        sel       = (reg_addr == MCR_ADDR);
    wire [1:0]  seq_field = measurement_control[MCR_SEQ_HI:MCR_SEQ_LO];
    wire        axes_all  = (&motion_axis_enable) & (&stillness_axis_enable); // R7
    wire        seq_req   = (seq_field == MCR_SEQ_LINKED) || (seq_field == MCR_SEQ_LOOPED);
    wire        sequenced = seq_req & axes_all; // R7
    wire        looped    = sequenced & (seq_field == MCR_SEQ_LOOPED); // R6
    wire        act_on    = !sequenced || (arm == MCR_ARM_ACT); // R4
    wire        still_on  = !sequenced || (arm == MCR_ARM_STILL); // R4
    wire        act_ev    = act_on & motion_hit;
    wire        still_ev  = still_on & stillness_hit;
    wire        doze      = sequenced & measurement_control[MCR_AUTODOZE_BIT] & still_ev; // R2 R3
    wire [4:0]  bw_sel;

    mcr_bw_decode i_mcr_bw_decode (
        .bw_code   (measurement_control[MCR_BW_HI:MCR_BW_LO]),
        .bw_onehot (bw_sel)
    );

    // arming toggles on each accepted event; default mode parks on activity
    always_comb begin
        next_arm = arm;
        case (arm)
            MCR_ARM_ACT: begin
                if (sequenced && act_ev)
                    next_arm = MCR_ARM_STILL; // R10
            end
            MCR_ARM_STILL: begin
                // default sequencing parks on activity so a later link starts there
                if (!sequenced || still_ev)
                    next_arm = MCR_ARM_ACT; // R10
            end
            default: next_arm = MCR_ARM_ACT;
        endcase
    end

    // register write; plain byte, every bit writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            measurement_control <= MCR_RESET; // R1
        else if (reg_wr && sel)
            measurement_control <= reg_wdata; // R1
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            arm <= MCR_ARM_ACT;
        else
            arm <= next_arm;
    end

    // pending flags: event set beats a status-read clear; looped mode never latches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motion_pending    <= 1'b0;
            stillness_pending <= 1'b0;
        end else begin
            motion_pending    <= !looped & (act_ev | (motion_pending & !status_rd)); // R4 R5 R6
            stillness_pending <= !looped & (still_ev | (stillness_pending & !status_rd)); // R6
        end
    end

    // registered outputs so the pins never glitch on decode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata         <= 8'h00;
            motion_armed      <= 1'b0;
            stillness_armed   <= 1'b0;
            wakeup_request    <= 1'b0;
            overrange_disable <= 1'b0;
            quiet_mode        <= 1'b0;
            lpf_corner_sel    <= 5'h01;
        end else begin
            reg_rdata         <= (reg_rd && sel) ? measurement_control : 8'h00; // R1
            motion_armed      <= act_on & motion_axis_enable != 3'h0;
            stillness_armed   <= still_on & stillness_axis_enable != 3'h0;
            wakeup_request    <= doze; // R2
            overrange_disable <= measurement_control[MCR_OR_DIS_BIT]; // R1
            quiet_mode        <= measurement_control[MCR_QUIET_BIT]; // R8
            lpf_corner_sel    <= bw_sel; // R9
        end
    end

    // assertions: register port, reset and the plain copies of the fields
    AST_RESET_VALUE: assert property (@(posedge clk) // R1
        $rose(rst_n) |-> measurement_control == MCR_RESET)
        else $error("register not at reset value");
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (!rst_n) // R1
        reg_wr && sel |=> measurement_control == $past(reg_wdata))
        else $error("write not stored");
    AST_WRITE_ONLY: assert property (@(posedge clk) disable iff (!rst_n) // R1
        !(reg_wr && sel) |=> $stable(measurement_control))
        else $error("register changed without a write");
    AST_READ_DATA: assert property (@(posedge clk) disable iff (!rst_n) // R1
        reg_rd && sel |=> reg_rdata == $past(measurement_control))
        else $error("read data does not match register");
    // idle read data stays zero so a host sampling late never sees a stale byte
    AST_READ_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // R1
        !(reg_rd && sel) |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_OVERRANGE: assert property (@(posedge clk) disable iff (!rst_n) // R1
        ##1 overrange_disable == $past(measurement_control[MCR_OR_DIS_BIT]))
        else $error("overrange flag not followed");
    AST_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // R8
        ##1 quiet_mode == $past(measurement_control[MCR_QUIET_BIT]))
        else $error("quiet bit not followed");

    // assertions: corner select, undefined codes must still give exactly one corner
    AST_BW_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n) // R9
        $onehot(lpf_corner_sel))
        else $error("corner select not one-hot");
    AST_BW_SLOWEST: assert property (@(posedge clk) disable iff (!rst_n) // R9
        measurement_control[MCR_BW_HI:MCR_BW_LO] == 3'h0 |=> lpf_corner_sel == 5'h01)
        else $error("code 0 did not pick the lowest corner");
    AST_BW_FASTEST: assert property (@(posedge clk) disable iff (!rst_n) // R9
        measurement_control[MCR_BW_HI:MCR_BW_LO] == MCR_BW_MAX |=> lpf_corner_sel == 5'h10)
        else $error("top code did not pick the highest corner");

    // assertions: auto-doze
    AST_DOZE: assert property (@(posedge clk) disable iff (!rst_n) // R2
        doze |=> wakeup_request)
        else $error("auto-doze missed");
    AST_NO_DOZE_LOW: assert property (@(posedge clk) disable iff (!rst_n) // R2
        !measurement_control[MCR_AUTODOZE_BIT] |=> !wakeup_request)
        else $error("wake-up asked with auto-doze clear");
    // the arming leaves stillness at once, so one stillness event gives one pulse
    AST_WAKE_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // R2
        wakeup_request |=> !wakeup_request)
        else $error("wake-up request longer than one cycle");
    AST_NO_DOZE_DEFAULT: assert property (@(posedge clk) disable iff (!rst_n) // R3
        !sequenced |=> !wakeup_request)
        else $error("doze in default mode");
    AST_WAKE_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // R3
        wakeup_request |-> $past(sequenced))
        else $error("wake-up asked outside linked or looped sequencing");

    // assertions: detectors, arming and pending flags
    AST_DEFAULT_BOTH: assert property (@(posedge clk) disable iff (!rst_n) // R4
        !sequenced |-> act_on && still_on)
        else $error("default mode lost a detector");
    AST_STILL_ARMED: assert property (@(posedge clk) disable iff (!rst_n) // R4
        !sequenced && stillness_axis_enable != 3'h0 |=> stillness_armed)
        else $error("stillness detector not armed in default sequencing");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n) // R4
        act_ev && !looped |=> motion_pending)
        else $error("motion event lost");
    AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // R4
        status_rd && !act_ev |=> !motion_pending)
        else $error("status read did not clear motion pending");
    AST_HOLD_STILL: assert property (@(posedge clk) disable iff (!rst_n) // R4
        stillness_pending && !status_rd && !looped |=> stillness_pending)
        else $error("stillness pending dropped without status read");
    AST_HOLD_PENDING: assert property (@(posedge clk) disable iff (!rst_n) // R5
        motion_pending && !status_rd && !looped |=> motion_pending)
        else $error("pending dropped without status read");
    AST_ARMED_OUT: assert property (@(posedge clk) disable iff (!rst_n) // R5
        sequenced && arm == MCR_ARM_STILL |=> !motion_armed)
        else $error("motion detector armed while stillness holds the turn");
    AST_LOOP_ACK: assert property (@(posedge clk) disable iff (!rst_n) // R6
        looped |=> !stillness_pending)
        else $error("looped mode latched an event");
    AST_LOOP_ACK_MOTION: assert property (@(posedge clk) disable iff (!rst_n) // R6
        looped |=> !motion_pending)
        else $error("looped mode latched a motion event");
    AST_ONE_ARMED: assert property (@(posedge clk) disable iff (!rst_n) // R7
        sequenced |-> act_on != still_on)
        else $error("two detectors armed in sequence");
    AST_SWAP: assert property (@(posedge clk) disable iff (!rst_n) // R10
        sequenced && arm == MCR_ARM_ACT && act_ev |=> arm == MCR_ARM_STILL)
        else $error("arming did not swap");
    AST_SWAP_BACK: assert property (@(posedge clk) disable iff (!rst_n) // R10
        sequenced && arm == MCR_ARM_STILL && still_ev |=> arm == MCR_ARM_ACT)
        else $error("arming did not swap back");
    AST_ARM_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n) // R10
        $onehot(arm))
        else $error("arming state not one-hot");

    // cover: the main scenarios the bench walks through
    COV_LINKED: cover property (@(posedge clk) sequenced && !looped && act_ev);
    COV_LOOPED: cover property (@(posedge clk) looped && still_ev);
    COV_DOZE:   cover property (@(posedge clk) doze);
    COV_STATUS_ACK: cover property (@(posedge clk) !sequenced && stillness_pending && status_rd);
    COV_PARTIAL_AXES: cover property (@(posedge clk) seq_req && !axes_all && still_ev);
endmodule

// ===== tb/mcr_host.sv
// host side model: issues register and status accesses over the byte port
// assumes strobes are taken on the rising edge and need no handshake back
`timescale 1ns/1ns
module mcr_host (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    output logic            status_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd, status_rd} = '0;

    // one strobe per call; s set means a status read, the host acknowledge
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d, input logic s);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd, status_rd} = {a, d, w, ~w & ~s, s};
        @(negedge clk);
        // released bus shows the inverse so a stale value never looks valid
        {reg_addr, reg_wdata, reg_wr, reg_rd, status_rd} = {~a, ~d, 3'h0};
    endtask
endmodule

// ===== tb/measurement_control_register_tb.sv
// bench for the measurement control register block
// assumes mcr_top and the host model; detector hits come from here
`timescale 1ns/1ns
module measurement_control_register_tb;
    import mcr_pkg::*;
    logic       clk, rst_n, reg_wr, reg_rd, status_rd, motion_hit, stillness_hit, rd_d;
    logic       motion_armed, stillness_armed, motion_pending, stillness_pending;
    logic       wakeup_request, overrange_disable, quiet_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [2:0] motion_axis_enable, stillness_axis_enable;
    logic [4:0] lpf_corner_sel;
    logic [7:0] exp_q[$];
    int         err_total = 0, tests_run = 0, wake_cnt = 0;

    mcr_top i_mcr_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_rd(status_rd),
        .motion_axis_enable(motion_axis_enable), .stillness_axis_enable(stillness_axis_enable),
        .motion_hit(motion_hit), .stillness_hit(stillness_hit), .motion_armed(motion_armed),
        .stillness_armed(stillness_armed), .motion_pending(motion_pending),
        .stillness_pending(stillness_pending), .wakeup_request(wakeup_request),
        .overrange_disable(overrange_disable), .quiet_mode(quiet_mode),
        .lpf_corner_sel(lpf_corner_sel));
    mcr_host i_mcr_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .status_rd(status_rd));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // read: note the expected byte, the monitor compares it when data shows
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_mcr_host.acc(a, 1'b0, 8'h00, 1'b0);
    endtask
    task automatic wr(input logic [7:0] d);
        i_mcr_host.acc(MCR_ADDR, 1'b1, d, 1'b0);
        repeat (2) @(negedge clk);
    endtask
    // one-cycle detector hit, then time for arming and flags to settle
    task automatic hit(input logic m, input logic s);
        @(negedge clk);
        {motion_hit, stillness_hit} = {m, s};
        @(negedge clk);
        {motion_hit, stillness_hit} = 2'b00;
        repeat (3) @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // read data stands one cycle after the taken strobe; wake pulses are counted
    always @(posedge clk) begin
        rd_d <= reg_rd;
        wake_cnt <= wake_cnt + int'(wakeup_request);
    end
    always @(negedge clk) if (rd_d === 1'b1) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'hd97313e5));
        {rst_n, motion_hit, stillness_hit} = 3'h0;
        {motion_axis_enable, stillness_axis_enable} = 6'h3f;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk("lpf_corner_sel", 8'h01, lpf_corner_sel);
        rd(MCR_ADDR, MCR_RESET);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom());
            v[2:0] = i[2:0];
            wr(v);
            rd(MCR_ADDR, v);
            chk("quiet_mode", v[3], quiet_mode);
            chk("overrange_disable", v[7], overrange_disable);
            chk("lpf_corner_sel", (i < 5) ? 8'(1 << i) : 8'h01, lpf_corner_sel);
        end
        i_mcr_host.acc(8'h3f, 1'b1, 8'hff, 1'b0);
        rd(8'h3f, 8'h00);
        rd(MCR_ADDR, v);
        wr(8'h40);
        chk("both_armed", 8'h3, {motion_armed, stillness_armed});
        hit(1'b0, 1'b1);
        chk("stillness_pending", 8'h1, stillness_pending);
        i_mcr_host.acc(MCR_ADDR, 1'b0, 8'h00, 1'b1);
        chk("stillness_pending", 8'h0, stillness_pending);
        // partial axis enables fall back to simultaneous detection
        motion_axis_enable = 3'h3;
        wr(8'h50);
        chk("both_armed", 8'h3, {motion_armed, stillness_armed});
        hit(1'b0, 1'b1);
        chk("wake_cnt", 8'h0, 8'(wake_cnt));
        motion_axis_enable = 3'h7;
        wr(8'h50);
        hit(1'b1, 1'b0);
        chk("armed", 8'h1, {motion_armed, stillness_armed});
        chk("motion_pending", 8'h1, motion_pending);
        hit(1'b0, 1'b1);
        chk("armed", 8'h2, {motion_armed, stillness_armed});
        chk("wake_cnt", 8'h1, 8'(wake_cnt));
        i_mcr_host.acc(MCR_ADDR, 1'b0, 8'h00, 1'b1);
        chk("pending", 8'h0, {motion_pending, stillness_pending});
        wr(8'h20);
        hit(1'b1, 1'b0);
        chk("pending", 8'h0, {motion_pending, stillness_pending});
        chk("armed", 8'h1, {motion_armed, stillness_armed});
        hit(1'b0, 1'b1);
        chk("armed", 8'h2, {motion_armed, stillness_armed});
        chk("wake_cnt", 8'h1, 8'(wake_cnt));
        // the undefined sequencing code behaves as default: both armed, no auto-doze
        wr(8'h70);
        hit(1'b0, 1'b1);
        chk("both_armed", 8'h3, {motion_armed, stillness_armed});
        chk("wake_cnt", 8'h1, 8'(wake_cnt));
        // a reset in mid-run brings every field and flag back to zero
        wr(8'hcb);
        chk("or_quiet", 8'h3, {overrange_disable, quiet_mode});
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk("or_quiet", 8'h0, {overrange_disable, quiet_mode});
        chk("lpf_corner_sel", 8'h01, lpf_corner_sel);
        chk("pending", 8'h0, {motion_pending, stillness_pending});
        rd(MCR_ADDR, MCR_RESET);
        repeat (2) @(negedge clk);
        chk("reads_left", 8'h0, 8'(exp_q.size()));
        report_and_stop();
    end
endmodule
